// [design/opcode_classifier.sv]
// Combinational decoder that maps a prefix and opcode to an operation kind.
`timescale 1ns/100ps
`default_nettype none
module opcode_classifier
	import stack_exec_pkg::*;
(
	// Instruction bytes.
	input wire logic has_prefix,
	input wire logic [7:0] prefix,
	input wire logic [7:0] opcode,
	// Decoded result.
	output op_kind_t kind,
	output logic [1:0] pair_select_field,
	output logic use_y,
	output logic [4:0] t_total
);
	// Prefixed forms only accept the index opcodes; anything else is unsupported here.
	always_comb begin
		kind = KIND_NONE;
		t_total = T_SWAP_REG;
		pair_select_field = opcode[SEL_HI:SEL_LO];
		use_y = has_prefix && (prefix == OP_PREFIX_Y);
		if (has_prefix && (prefix == OP_PREFIX_X || prefix == OP_PREFIX_Y)) begin
			if (opcode == OP_PULL_INDEX) begin
				kind = KIND_PULL_INDEX;
				t_total = T_PULL_INDEX;
			end else if (opcode == OP_PUSH_INDEX) begin
				kind = KIND_PUSH_INDEX;
				t_total = T_PUSH_INDEX;
			end else if (opcode == OP_SWAP_TOP) begin
				kind = KIND_SWAP_TOP;
				t_total = T_SWAP_TOP_INDEX;
			end
		end else if (!has_prefix) begin
			if ((opcode & PULL_PAIR_MASK) == PULL_PAIR_CODE) begin
				kind = KIND_PULL_PAIR;
				t_total = T_PULL_PAIR;
			end else if (opcode == OP_SWAP_TOP) begin
				kind = KIND_SWAP_TOP;
				t_total = T_SWAP_TOP_PTR;
			end else if (opcode == OP_SWAP_PTR_PAIRS) begin
				kind = KIND_SWAP_PTRS;
			end else if (opcode == OP_SWAP_ACC_FLAGS) begin
				kind = KIND_SWAP_ACC;
			end else if (opcode == OP_SWAP_ALL_PAIRS) begin
				kind = KIND_SWAP_ALL;
			end
		end
	end
endmodule
`default_nettype wire

// [design/stack_pop_exchange_exec.sv]
// Executes stack pull, stack store of index registers and register exchange instructions.
// How it works
// - Index-y store writes high at top-1, low at top-2, pointer minus two, 15 T.
// - Pull-pair select bits 5:4 pick count, two, ptr or acc/flags pair.
// - Pull-pair reads low at top, bumps pointer, reads high, bumps again; 10 T.
// - Prefix DD then E1 pulls index x, low then high, pointer plus two; 14 T.
// - Index-y pull loads low from top, high from next, pointer plus two; 14 T.
// - Pointer-pair swap exchanges pair two and pointer pair in 4 T.
// - Opcode 08 swaps acc/flags pair with its shadow in 4 T.
// - Opcode D9 swaps the three general pairs with shadows in 4 T.
// - Pointer pair swaps with stack top, low at top, high at top+1; 19 T.
// - Swaps with stack top leave the stack pointer unchanged.
// - Prefix DD then E3 swaps index x with stack top bytes.
// - The stack pointer is a 16-bit register addressing the stack top.
// - Index-y store decrements, writes high, decrements, writes low.
`timescale 1ns/100ps
`default_nettype none
module stack_pop_exchange_exec
	import stack_exec_pkg::*;
(
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst,
	// Instruction issue from the core.
	input wire logic start,
	input wire logic has_prefix,
	input wire logic [7:0] prefix,
	input wire logic [7:0] opcode,
	output logic busy,
	output logic done,
	output logic illegal,
	// Memory port, one byte per access.
	output logic mem_rd,
	output logic mem_wr,
	output logic [15:0] mem_addr,
	output logic [7:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [7:0] mem_rdata,
	// Register contents.
	output logic [15:0] pair_count,
	output logic [15:0] pair_two,
	output logic [15:0] pair_ptr,
	output logic [15:0] acc_flags_pair,
	output logic [15:0] shadow_pair_count,
	output logic [15:0] shadow_pair_two,
	output logic [15:0] shadow_pair_ptr,
	output logic [15:0] shadow_acc_flags,
	output logic [15:0] index_reg_x,
	output logic [15:0] index_reg_y,
	output logic [15:0] stack_pointer
);
	typedef enum {
		ST_IDLE, ST_RD_LO, ST_RD_HI, ST_WR_HI, ST_WR_LO, ST_WAIT
	} state_t;

	state_t state, next_state;
	op_kind_t kind, dec_kind, next_kind;
	logic [1:0] sel, dec_sel, next_sel;
	logic use_y, dec_use_y, next_use_y;
	logic [4:0] dec_total;
	logic timer_load, timer_expired;
	logic [15:0] old_word, next_old_word;
	logic [7:0] lo_byte, next_lo_byte;
	logic [15:0] next_pair_count, next_pair_two, next_pair_ptr, next_acc_flags_pair;
	logic [15:0] next_shadow_pair_count, next_shadow_pair_two, next_shadow_pair_ptr;
	logic [15:0] next_shadow_acc_flags, next_index_reg_x, next_index_reg_y;
	logic [15:0] next_stack_pointer;
	logic next_mem_rd, next_mem_wr, next_done, next_illegal;
	logic [15:0] next_mem_addr;
	logic [7:0] next_mem_wdata;
	logic [15:0] swap_target;

	// Decoder for the issued instruction bytes.
	opcode_classifier u_classifier (
		.has_prefix(has_prefix),
		.prefix(prefix),
		.opcode(opcode),
		.kind(dec_kind),
		.pair_select_field(dec_sel),
		.use_y(dec_use_y),
		.t_total(dec_total)
	);

	// Paces every instruction to its full T-state count even when memory answers quickly.
	tstate_timer u_timer (
		.sys_clk(sys_clk),
		.rst(rst),
		.load(timer_load),
		.total(dec_total),
		.expired(timer_expired)
	);

	// Register that a stack-top swap works on.
	always_comb begin
		if (kind == KIND_SWAP_TOP && sel == SEL_ACC) begin
			swap_target = use_y ? index_reg_y : index_reg_x;
		end else begin
			swap_target = pair_ptr;
		end
	end

	// Sequencer: register swaps finish in the issue cycle's window, memory forms walk bytes.
	always_comb begin
		next_state = state;
		next_kind = kind;
		next_sel = sel;
		next_use_y = use_y;
		next_old_word = old_word;
		next_lo_byte = lo_byte;
		next_pair_count = pair_count;
		next_pair_two = pair_two;
		next_pair_ptr = pair_ptr;
		next_acc_flags_pair = acc_flags_pair;
		next_shadow_pair_count = shadow_pair_count;
		next_shadow_pair_two = shadow_pair_two;
		next_shadow_pair_ptr = shadow_pair_ptr;
		next_shadow_acc_flags = shadow_acc_flags;
		next_index_reg_x = index_reg_x;
		next_index_reg_y = index_reg_y;
		next_stack_pointer = stack_pointer;
		next_mem_rd = 1'b0;
		next_mem_wr = 1'b0;
		next_mem_addr = mem_addr;
		next_mem_wdata = mem_wdata;
		next_done = 1'b0;
		next_illegal = 1'b0;
		timer_load = 1'b0;
		case (state)
			ST_IDLE: begin
				if (start) begin
					timer_load = 1'b1;
					next_kind = dec_kind;
					next_use_y = dec_use_y;
					// Index forms reuse the select slot to mark an index target.
					next_sel = (dec_kind == KIND_PULL_PAIR) ? dec_sel : SEL_ACC;
					if (dec_kind == KIND_SWAP_TOP && !has_prefix) begin
						next_sel = SEL_PTR;
					end
					case (dec_kind)
						KIND_PULL_PAIR, KIND_PULL_INDEX, KIND_SWAP_TOP: begin
							next_state = ST_RD_LO;
							next_mem_rd = 1'b1;
							next_mem_addr = stack_pointer;
						end
						KIND_PUSH_INDEX: begin
							next_state = ST_WR_HI;
							next_old_word = dec_use_y ? index_reg_y : index_reg_x;
							next_mem_wr = 1'b1;
							next_mem_addr = stack_pointer - 16'h0001;
							next_mem_wdata = next_old_word[15:8];
							next_stack_pointer = stack_pointer - 16'h0001;
						end
						KIND_SWAP_PTRS: begin
							next_pair_two = pair_ptr;
							next_pair_ptr = pair_two;
							next_state = ST_WAIT;
						end
						KIND_SWAP_ACC: begin
							next_acc_flags_pair = shadow_acc_flags;
							next_shadow_acc_flags = acc_flags_pair;
							next_state = ST_WAIT;
						end
						KIND_SWAP_ALL: begin
							next_pair_count = shadow_pair_count;
							next_shadow_pair_count = pair_count;
							next_pair_two = shadow_pair_two;
							next_shadow_pair_two = pair_two;
							next_pair_ptr = shadow_pair_ptr;
							next_shadow_pair_ptr = pair_ptr;
							next_state = ST_WAIT;
						end
						default: begin
							next_illegal = 1'b1;
							next_done = 1'b1;
						end
					endcase
				end
			end
			ST_RD_LO: begin
				next_mem_rd = 1'b1;
				if (mem_ack) begin
					next_lo_byte = mem_rdata;
					next_mem_addr = mem_addr + 16'h0001;
					if (kind != KIND_SWAP_TOP) begin
						next_stack_pointer = stack_pointer + 16'h0001;
					end
					next_state = ST_RD_HI;
				end
			end
			ST_RD_HI: begin
				next_mem_rd = 1'b1;
				if (mem_ack) begin
					next_mem_rd = 1'b0;
					if (kind == KIND_SWAP_TOP) begin
						// Old register goes out high byte first at top+1, then low at top.
						next_old_word = swap_target;
						if (sel == SEL_PTR) begin
							next_pair_ptr = {mem_rdata, lo_byte};
						end else if (use_y) begin
							next_index_reg_y = {mem_rdata, lo_byte};
						end else begin
							next_index_reg_x = {mem_rdata, lo_byte};
						end
						next_mem_wr = 1'b1;
						next_mem_wdata = swap_target[15:8];
						next_state = ST_WR_HI;
					end else begin
						next_stack_pointer = stack_pointer + 16'h0001;
						next_state = ST_WAIT;
						if (kind == KIND_PULL_INDEX) begin
							if (use_y) begin
								next_index_reg_y = {mem_rdata, lo_byte};
							end else begin
								next_index_reg_x = {mem_rdata, lo_byte};
							end
						end else begin
							case (sel)
								SEL_COUNT: next_pair_count = {mem_rdata, lo_byte};
								SEL_TWO: next_pair_two = {mem_rdata, lo_byte};
								SEL_PTR: next_pair_ptr = {mem_rdata, lo_byte};
								default: next_acc_flags_pair = {mem_rdata, lo_byte};
							endcase
						end
					end
				end
			end
			ST_WR_HI: begin
				next_mem_wr = 1'b1;
				if (mem_ack) begin
					next_mem_addr = mem_addr - 16'h0001;
					next_mem_wdata = old_word[7:0];
					if (kind == KIND_PUSH_INDEX) begin
						next_stack_pointer = stack_pointer - 16'h0001;
					end
					next_state = ST_WR_LO;
				end
			end
			ST_WR_LO: begin
				next_mem_wr = 1'b1;
				if (mem_ack) begin
					next_mem_wr = 1'b0;
					next_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (timer_expired) begin
					next_done = 1'b1;
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// State and architectural registers.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state <= ST_IDLE;
			kind <= KIND_NONE;
			sel <= SEL_COUNT;
			use_y <= 1'b0;
			old_word <= RESET_WORD;
			lo_byte <= 8'h00;
			pair_count <= RESET_WORD;
			pair_two <= RESET_WORD;
			pair_ptr <= RESET_WORD;
			acc_flags_pair <= RESET_WORD;
			shadow_pair_count <= RESET_WORD;
			shadow_pair_two <= RESET_WORD;
			shadow_pair_ptr <= RESET_WORD;
			shadow_acc_flags <= RESET_WORD;
			index_reg_x <= RESET_WORD;
			index_reg_y <= RESET_WORD;
			stack_pointer <= RESET_SP;
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			mem_addr <= RESET_WORD;
			mem_wdata <= 8'h00;
			done <= 1'b0;
			illegal <= 1'b0;
		end else begin
			state <= next_state;
			kind <= next_kind;
			sel <= next_sel;
			use_y <= next_use_y;
			old_word <= next_old_word;
			lo_byte <= next_lo_byte;
			pair_count <= next_pair_count;
			pair_two <= next_pair_two;
			pair_ptr <= next_pair_ptr;
			acc_flags_pair <= next_acc_flags_pair;
			shadow_pair_count <= next_shadow_pair_count;
			shadow_pair_two <= next_shadow_pair_two;
			shadow_pair_ptr <= next_shadow_pair_ptr;
			shadow_acc_flags <= next_shadow_acc_flags;
			index_reg_x <= next_index_reg_x;
			index_reg_y <= next_index_reg_y;
			stack_pointer <= next_stack_pointer;
			mem_rd <= next_mem_rd;
			mem_wr <= next_mem_wr;
			mem_addr <= next_mem_addr;
			mem_wdata <= next_mem_wdata;
			done <= next_done;
			illegal <= next_illegal;
		end
	end

	// Busy covers the whole instruction so the core cannot issue over it.
	assign busy = (state != ST_IDLE);
endmodule
`default_nettype wire

// [design/tstate_timer.sv]
// Counter that stretches each instruction to its documented number of T-states.
`timescale 1ns/100ps
`default_nettype none
module tstate_timer
	import stack_exec_pkg::*;
(
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst,
	// Control.
	input wire logic load,
	input wire logic [4:0] total,
	// Status.
	output logic expired
);
	logic [4:0] count;
	logic [4:0] next_count;

	// Loads total minus two because the start edge is the first T-state and done is registered.
	// The done pulse then shows in the cycle after the last T-state, so a new start can follow.
	always_comb begin
		next_count = count;
		if (load) begin
			next_count = total - 5'h02;
		end else if (count != 5'h00) begin
			next_count = count - 5'h01;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			count <= 5'h00;
		end else begin
			count <= next_count;
		end
	end

	assign expired = (count == 5'h00);
endmodule
`default_nettype wire

// [include/stack_exec_pkg.sv]
// Package with opcodes, pair selectors, timing and reset values for the stack and exchange unit.
package stack_exec_pkg;
	// Opcode bytes.
	localparam logic [7:0] OP_PREFIX_X = 8'hDD;
	localparam logic [7:0] OP_PREFIX_Y = 8'hFD;
	localparam logic [7:0] OP_PULL_INDEX = 8'hE1;
	localparam logic [7:0] OP_PUSH_INDEX = 8'hE5;
	localparam logic [7:0] OP_SWAP_TOP = 8'hE3;
	localparam logic [7:0] OP_SWAP_PTR_PAIRS = 8'hEB;
	localparam logic [7:0] OP_SWAP_ACC_FLAGS = 8'h08;
	localparam logic [7:0] OP_SWAP_ALL_PAIRS = 8'hD9;
	// Pull-pair opcode: 11qq0001; the select field sits in bits 5:4.
	localparam logic [7:0] PULL_PAIR_MASK = 8'hCF;
	localparam logic [7:0] PULL_PAIR_CODE = 8'hC1;
	localparam int SEL_HI = 5;
	localparam int SEL_LO = 4;
	// Pair select codes.
	localparam logic [1:0] SEL_COUNT = 2'h0;
	localparam logic [1:0] SEL_TWO = 2'h1;
	localparam logic [1:0] SEL_PTR = 2'h2;
	localparam logic [1:0] SEL_ACC = 2'h3;
	// T-state totals per instruction, counted one T-state per clock.
	localparam logic [4:0] T_PULL_PAIR = 5'h0A;
	localparam logic [4:0] T_PULL_INDEX = 5'h0E;
	localparam logic [4:0] T_PUSH_INDEX = 5'h0F;
	localparam logic [4:0] T_SWAP_REG = 5'h04;
	localparam logic [4:0] T_SWAP_TOP_PTR = 5'h13;
	localparam logic [4:0] T_SWAP_TOP_INDEX = 5'h17;
	// Reset values.
	localparam logic [15:0] RESET_WORD = 16'h0000;
	localparam logic [15:0] RESET_SP = 16'hFFFF;
	// Decoded operation kinds.
	typedef enum {
		KIND_NONE, KIND_PULL_PAIR, KIND_PULL_INDEX, KIND_PUSH_INDEX,
		KIND_SWAP_TOP, KIND_SWAP_PTRS, KIND_SWAP_ACC, KIND_SWAP_ALL
	} op_kind_t;
endpackage

// [test/stack_exec_sva.sv]
// Concurrent checks on the ports of the stack and exchange unit.
`timescale 1ns/100ps
`default_nettype none
module stack_exec_sva (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst,
	// Issue.
	input wire logic start,
	input wire logic has_prefix,
	input wire logic [7:0] prefix,
	input wire logic [7:0] opcode,
	input wire logic busy,
	input wire logic done,
	input wire logic illegal,
	// Memory.
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	input wire logic mem_ack,
	// Registers.
	input wire logic [15:0] pair_count, pair_two, pair_ptr, acc_flags_pair,
	input wire logic [15:0] shadow_pair_count, shadow_pair_two, shadow_pair_ptr,
	input wire logic [15:0] shadow_acc_flags, index_reg_x, index_reg_y, stack_pointer
);
	logic go, idx_ok, pull_op, sw_op, pull_run, top_run, push_run;
	logic [4:0] want, want_q, cnt;
	logic [15:0] base0, push_val, wr_n;
	assign go = start && !busy;
	assign idx_ok = has_prefix && (prefix == 8'hDD || prefix == 8'hFD);
	assign pull_op = (!has_prefix && (opcode & 8'hCF) == 8'hC1) || (idx_ok && opcode == 8'hE1);
	assign sw_op = !has_prefix && (opcode == 8'hEB || opcode == 8'h08 || opcode == 8'hD9);
	// Shortest legal length of the instruction being issued.
	always_comb begin
		want = 5'h04;
		if (pull_op) want = has_prefix ? 5'h0E : 5'h0A;
		if (idx_ok && opcode == 8'hE5) want = 5'h0F;
		if (opcode == 8'hE3) want = has_prefix ? 5'h17 : 5'h13;
	end
	// Track the running instruction; the count saturates so slow memory cannot wrap it.
	always_ff @(posedge sys_clk) begin
		if (rst || (done && !go)) begin
			pull_run <= 1'b0;
			top_run <= 1'b0;
			push_run <= 1'b0;
		end else if (go) begin
			pull_run <= pull_op;
			top_run <= opcode == 8'hE3 && (idx_ok || !has_prefix);
			push_run <= idx_ok && opcode == 8'hE5;
		end
		if (go) begin
			cnt <= 5'h01;
			want_q <= want;
			base0 <= stack_pointer;
			wr_n <= 16'h0000;
			push_val <= prefix == 8'hFD ? index_reg_y : index_reg_x;
		end else begin
			if (cnt != 5'h1F) cnt <= cnt + 5'h01;
			if (mem_wr && mem_ack) wr_n <= wr_n + 16'h0001;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	time_floor_a: assert property (done && !illegal |-> cnt >= want_q)
		else $error("instruction finished too early");
	swap_time_a: assert property (go && sw_op |-> ##4 done)
		else $error("register swap did not finish in four cycles");
	ptr_swap_a: assert property (go && sw_op && opcode == 8'hEB |=>
		pair_two == $past(pair_ptr) && pair_ptr == $past(pair_two)) else $error("pointer swap wrong");
	acc_swap_a: assert property (go && sw_op && opcode == 8'h08 |=>
		acc_flags_pair == $past(shadow_acc_flags) && shadow_acc_flags == $past(acc_flags_pair))
		else $error("acc swap wrong");
	all_swap_a: assert property (go && sw_op && opcode == 8'hD9 |=>
		pair_count == $past(shadow_pair_count) && shadow_pair_count == $past(pair_count) &&
		pair_two == $past(shadow_pair_two) && pair_ptr == $past(shadow_pair_ptr) &&
		shadow_pair_two == $past(pair_two) && shadow_pair_ptr == $past(pair_ptr))
		else $error("swap of all pairs wrong");
	top_ptr_hold_a: assert property (top_run |-> stack_pointer == base0)
		else $error("stack pointer moved during swap with top");
	pull_addr_a: assert property (go && pull_op |=> mem_rd && mem_addr == $past(stack_pointer))
		else $error("pull did not read the stack top first");
	pull_ptr_a: assert property (done && pull_run |-> stack_pointer == base0 + 16'h0002)
		else $error("pull left wrong stack pointer");
	push_order_a: assert property (push_run && mem_wr |-> mem_addr == base0 - 16'h0001 - wr_n &&
		mem_wdata == (wr_n[0] ? push_val[7:0] : push_val[15:8])) else $error("store order wrong");
	push_ptr_a: assert property (done && push_run |-> stack_pointer == base0 - 16'h0002)
		else $error("store left wrong stack pointer");
	cover property (done && pull_run);
	cover property (done && top_run);
	cover property (done && illegal);
	cover property (mem_rd && !mem_ack);
endmodule
`default_nettype wire

// [test/stack_mem_model.sv]
// Byte-wide stack memory that answers each access after a chosen number of wait cycles.
`timescale 1ns/100ps
`default_nettype none
module stack_mem_model (
	// Clock.
	input wire logic sys_clk,
	// Memory port.
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	output logic mem_ack,
	output logic [7:0] mem_rdata,
	// Wait cycles before each answer.
	input wire logic [1:0] mem_delay
);
	logic [7:0] mem [0:65535];
	logic [7:0] last = 8'h00;
	logic [1:0] waited = 2'h0;
	// Outside an answer the data lines show junk, so a late sample never looks right.
	assign mem_ack = (mem_rd || mem_wr) && waited >= mem_delay;
	assign mem_rdata = mem_ack ? mem[mem_addr] : ~last;
	// Count wait cycles and store written bytes.
	always @(posedge sys_clk) begin
		waited <= (mem_ack || !(mem_rd || mem_wr)) ? 2'h0 : waited + 2'h1;
		if (mem_ack) last <= mem_rd ? mem[mem_addr] : mem_wdata;
		if (mem_ack && mem_wr) mem[mem_addr] <= mem_wdata;
	end
endmodule
`default_nettype wire

// [test/stack_pop_exchange_exec_bench.sv]
// Self-checking bench for the stack pull, store and exchange unit.
`timescale 1ns/100ps
`default_nettype none
module stack_pop_exchange_exec_bench;
	logic sys_clk = 1'b0, rst = 1'b1, start = 1'b0, has_prefix = 1'b0;
	logic busy, done, illegal, mem_rd, mem_wr, mem_ack;
	logic [7:0] prefix = 8'h00, opcode = 8'h00, mem_rdata, mem_wdata;
	logic [15:0] mem_addr;
	logic [1:0] mem_delay = 2'h0;
	logic [15:0] dut_reg [0:10];
	logic [15:0] m [0:10];
	logic [7:0] m_mem [0:65535];
	logic [7:0] ops [0:8] = '{8'hC1, 8'hD1, 8'hE1, 8'hF1, 8'hE5, 8'hE3, 8'hEB, 8'h08, 8'hD9};
	int errors = 0, checks = 0, cycles = 0;
	stack_pop_exchange_exec u_dut (.sys_clk(sys_clk), .rst(rst), .start(start),
		.has_prefix(has_prefix), .prefix(prefix), .opcode(opcode), .busy(busy), .done(done),
		.illegal(illegal), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.pair_count(dut_reg[0]), .pair_two(dut_reg[1]), .pair_ptr(dut_reg[2]),
		.acc_flags_pair(dut_reg[3]), .shadow_pair_count(dut_reg[4]), .shadow_pair_two(dut_reg[5]),
		.shadow_pair_ptr(dut_reg[6]), .shadow_acc_flags(dut_reg[7]), .index_reg_x(dut_reg[8]),
		.index_reg_y(dut_reg[9]), .stack_pointer(dut_reg[10]));
	stack_mem_model u_mem (.sys_clk(sys_clk), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.mem_delay(mem_delay));
	// Clock at 40 MHz.
	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end
	// A hang counts as a mismatch and ends the run.
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 30000) begin
			errors++;
			stop_test();
		end
	end
	task automatic stop_test;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Model starts from the chosen reset values.
	task automatic model_reset;
		foreach (m[i]) m[i] = 16'h0000;
		m[10] = 16'hFFFF;
	endtask
	// Model one instruction, issue it, optionally poke start while busy, then compare all.
	task automatic run(input logic h, input logic [7:0] p, input logic [7:0] o, input logic poke);
		logic [15:0] base, t;
		int r, tt, n;
		logic ill;
		base = m[10];
		ill = 1'b0;
		tt = 4;
		r = h ? ((p == 8'hDD) ? 8 : 9) : 2;
		if (h && p != 8'hDD && p != 8'hFD) ill = 1'b1;
		else if ((!h && (o & 8'hCF) == 8'hC1) || (h && o == 8'hE1)) begin
			if (!h) r = o[5:4];
			m[r] = {m_mem[base + 16'h1], m_mem[base]};
			m[10] = base + 16'h2;
			tt = h ? 14 : 10;
		end else if (h && o == 8'hE5) begin
			m_mem[base - 16'h1] = m[r][15:8];
			m_mem[base - 16'h2] = m[r][7:0];
			m[10] = base - 16'h2;
			tt = 15;
		end else if (o == 8'hE3) begin
			t = m[r];
			m[r] = {m_mem[base + 16'h1], m_mem[base]};
			{m_mem[base + 16'h1], m_mem[base]} = t;
			tt = h ? 23 : 19;
		end else if (!h && o == 8'hEB) {m[1], m[2]} = {m[2], m[1]};
		else if (!h && o == 8'h08) {m[3], m[7]} = {m[7], m[3]};
		else if (!h && o == 8'hD9) begin
			{m[0], m[1], m[2], m[4], m[5], m[6]} = {m[4], m[5], m[6], m[0], m[1], m[2]};
		end else ill = 1'b1;
		if (ill) tt = 1;
		@(posedge sys_clk);
		start <= 1'b1;
		has_prefix <= h;
		prefix <= p;
		opcode <= o;
		n = 0;
		do begin
			@(posedge sys_clk);
			start <= poke && n == 1;
			opcode <= (poke && n == 1) ? 8'h08 : o;
			n++;
			#1;
		end while (done !== 1'b1 && n < 100);
		if (mem_delay == 2'h0) cmp16(16'(n), 16'(tt));
		else cmp16({15'h0, n >= tt}, 16'h0001);
		// Busy must already be low in the done cycle so the next issue is not lost.
		cmp16({13'h0, busy, done, illegal}, {13'h0, 1'b0, 1'b1, ill});
		for (int i = 0; i < 11; i++) cmp16(dut_reg[i], m[i]);
		for (int i = -2; i < 2; i++) cmp8(u_mem.mem[base + 16'(i)], m_mem[base + 16'(i)]);
	endtask
	// Main sequence.
	initial begin
		void'($urandom(70480));
		for (int i = 0; i < 65536; i++) begin
			m_mem[i] = 8'($urandom);
			u_mem.mem[i] = m_mem[i];
		end
		model_reset();
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		#1;
		for (int i = 0; i < 11; i++) cmp16(dut_reg[i], m[i]);
		$display("reset values test done");
		for (int s = 0; s < 4; s++) run(1'b0, 8'h00, 8'hC1 | 8'(s << 4), 1'b0);
		run(1'b1, 8'hDD, 8'hE1, 1'b0);
		run(1'b1, 8'hFD, 8'hE1, 1'b1);
		$display("pull test done");
		run(1'b0, 8'h00, 8'hEB, 1'b1);
		run(1'b0, 8'h00, 8'h08, 1'b0);
		run(1'b0, 8'h00, 8'hD9, 1'b0);
		$display("register swap test done");
		run(1'b0, 8'h00, 8'hE3, 1'b0);
		run(1'b1, 8'hDD, 8'hE3, 1'b0);
		run(1'b1, 8'hFD, 8'hE3, 1'b0);
		run(1'b1, 8'hFD, 8'hE5, 1'b1);
		run(1'b1, 8'hDD, 8'hE5, 1'b0);
		$display("stack swap and store test done");
		run(1'b1, 8'h12, 8'hE1, 1'b0);
		run(1'b0, 8'h00, 8'h00, 1'b0);
		run(1'b1, 8'hDD, 8'hEB, 1'b0);
		$display("refused opcode test done");
		for (int k = 0; k < 80; k++) begin
			mem_delay <= 2'($urandom);
			run(1'($urandom), ($urandom % 5 == 0) ? 8'($urandom) : (($urandom % 2) ? 8'hDD : 8'hFD),
				ops[$urandom % 9], 1'($urandom));
			if (k == 40) begin
				@(posedge sys_clk);
				rst <= 1'b1;
				repeat (2) @(posedge sys_clk);
				rst <= 1'b0;
				model_reset();
			end
		end
		$display("random slow memory test done");
		stop_test();
	end
endmodule
bind stack_pop_exchange_exec stack_exec_sva u_sva (.sys_clk, .rst, .start, .has_prefix, .prefix,
	.opcode, .busy, .done, .illegal, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_ack,
	.pair_count, .pair_two, .pair_ptr, .acc_flags_pair, .shadow_pair_count, .shadow_pair_two,
	.shadow_pair_ptr, .shadow_acc_flags, .index_reg_x, .index_reg_y, .stack_pointer);
`default_nettype wire
